// ### hjcu_ctrl.sv
// Functional notes
// R1: Idle bit 0 selects low-power mode with timed automatic measurements.
// R2: Idle bit 1 starts a measurement only after reset, soft reset or the Y readout acknowledge.
// R3: Bits 6:4 choose the low-power wake-up interval.
// R4: Codes map to 20,40,80,100,140,200,260,320 ms; default code is 111.
// R5: Interrupt disable bit 1 holds the interrupt pin released.
// R6: Data-ready mode asserts after each low-power measurement, idle mode 450 us after the Y readout acknowledge.
// R7: The Y readout acknowledge releases the interrupt.
// R8: Dead-zone mode asserts only when the position leaves the threshold box.
// R9: Dead-zone interrupt reasserts at the next measurement while still outside.
// R10: Host should pair dead-zone interrupt with low-power mode.
// R11: Soft reset bit reloads all registers, then clears itself.
// R12: Valid bit reads 0 during conversion and 1 once coordinates are new.
// R13: Pointer on control, X or Y freezes the valid bit, X and Y; other control fields still update.
// R14: X and Y are signed eight-bit coordinates.
// R15: Four signed thresholds, read/write, reset to +5 and -5.
// R16: Control writes never alter the coordinate-ready flag, except a soft reset write, which clears it.
`timescale 1ns/1ps
module hjcu_ctrl #(
  parameter int unsigned MS_CYC = hjcu_pkg::MS_PER_S * hjcu_pkg::CLK_MHZ,
  parameter int unsigned IRQ_DLY_CYC =
    hjcu_pkg::IRQ_DLY_US * hjcu_pkg::CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic lk_clk,
  input wire logic lk_cmd_valid,
  output logic lk_cmd_ready,
  input wire logic [1:0] lk_cmd_kind,
  input wire logic [7:0] lk_cmd_addr,
  input wire logic [7:0] lk_cmd_data,
  input wire logic [7:0] lk_rd_addr,
  output logic [7:0] lk_rd_data,
  output logic meas_start,
  input wire logic meas_done,
  input wire logic [7:0] meas_x,
  input wire logic [7:0] meas_y,
  output logic irq_line_low_active,
  output logic irq_line_low_active_oe
);

  generate
    if (MS_CYC < 1 ||
        MS_CYC > 32'hFFFF_FFFF / hjcu_pkg::TB_MS_MAX) begin : g_ms
      $error("hjcu_ctrl: MS_CYC out of range");
    end
    if (IRQ_DLY_CYC < 1) begin : g_dly
      $error("hjcu_ctrl: IRQ_DLY_CYC must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic idle;
    logic [2:0] tb;
    logic int_dis;
    logic int_fn;
    logic srst;
    logic [3:0] srst_cnt;
    logic [7:0] ptr;
    logic [7:0] live_x;
    logic [7:0] live_y;
    logic live_valid;
    logic [7:0] vis_x;
    logic [7:0] vis_y;
    logic vis_valid;
    logic [7:0] xp;
    logic [7:0] xn;
    logic [7:0] yp;
    logic [7:0] yn;
    logic irq;
    hjcu_pkg::hjcu_meas_t meas;
    logic start;
    logic kick;
    logic [31:0] wake_cnt;
    logic dly_run;
    logic [31:0] dly_cnt;
    logic [hjcu_pkg::BANK_W-1:0] sent;
  } hjcu_core_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic [7:0] rd_data;
  } hjcu_link_t;

  localparam hjcu_core_t CORE_RST = '{
    idle: hjcu_pkg::CTRL_RST[hjcu_pkg::CTRL_IDLE_BIT],
    tb: hjcu_pkg::CTRL_RST[hjcu_pkg::CTRL_TB_MSB:hjcu_pkg::CTRL_TB_LSB],
    live_x: hjcu_pkg::COORD_RST,
    live_y: hjcu_pkg::COORD_RST,
    vis_x: hjcu_pkg::COORD_RST,
    vis_y: hjcu_pkg::COORD_RST,
    xp: hjcu_pkg::THR_POS_RST,
    xn: hjcu_pkg::THR_NEG_RST,
    yp: hjcu_pkg::THR_POS_RST,
    yn: hjcu_pkg::THR_NEG_RST,
    meas: hjcu_pkg::HJCU_MEAS_IDLE,
    kick: 1'b1,
    default: '0
  };

  hjcu_core_t q, d;
  hjcu_link_t lk_q, lk_d;
  logic lk_rst_n;
  logic cmd_valid;
  logic [hjcu_pkg::CMD_W-1:0] cmd_word;
  hjcu_pkg::hjcu_cmd_t cmd_kind;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_data;
  logic pub_valid;
  logic pub_ready;
  logic [hjcu_pkg::BANK_W-1:0] bank;
  logic [hjcu_pkg::BANK_W-1:0] lk_bank;
  logic [7:0] ctrl_byte;
  logic [31:0] wake_tgt;
  logic frozen;
  logic outside;

  // Link side: local reset release, then register read-back mux
  assign lk_rst_n = lk_q.rst_s2;

  always_comb begin
    lk_d = lk_q;
    lk_d.rst_s1 = 1'b1;
    lk_d.rst_s2 = lk_q.rst_s1;
    unique case (lk_rd_addr)
      hjcu_pkg::ADDR_CTRL: lk_d.rd_data = lk_bank[7:0];
      hjcu_pkg::ADDR_X: lk_d.rd_data = lk_bank[15:8];
      hjcu_pkg::ADDR_Y: lk_d.rd_data = lk_bank[23:16];
      hjcu_pkg::ADDR_XP: lk_d.rd_data = lk_bank[31:24];
      hjcu_pkg::ADDR_XN: lk_d.rd_data = lk_bank[39:32];
      hjcu_pkg::ADDR_YP: lk_d.rd_data = lk_bank[47:40];
      hjcu_pkg::ADDR_YN: lk_d.rd_data = lk_bank[55:48];
      default: lk_d.rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge lk_clk or negedge reset_n) begin
    if (!reset_n) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  assign lk_rd_data = lk_q.rd_data;

  hjcu_hs_word #(
    .W(hjcu_pkg::CMD_W)
  ) u_cmd (
    .src_clk(lk_clk),
    .src_rst_n(lk_rst_n),
    .src_valid(lk_cmd_valid),
    .src_ready(lk_cmd_ready),
    .src_data({lk_cmd_kind, lk_cmd_addr, lk_cmd_data}),
    .dst_clk(ref_clk),
    .dst_rst_n(reset_n),
    .dst_valid(cmd_valid),
    .dst_data(cmd_word)
  );

  hjcu_hs_word #(
    .W(hjcu_pkg::BANK_W)
  ) u_bank (
    .src_clk(ref_clk),
    .src_rst_n(reset_n),
    .src_valid(pub_valid),
    .src_ready(pub_ready),
    .src_data(bank),
    .dst_clk(lk_clk),
    .dst_rst_n(lk_rst_n),
    .dst_valid(),
    .dst_data(lk_bank)
  );

  assign cmd_kind = hjcu_pkg::hjcu_cmd_t'(cmd_word[17:16]);
  assign cmd_addr = cmd_word[15:8];
  assign cmd_data = cmd_word[7:0];

  assign ctrl_byte = {q.idle, q.tb, q.int_dis, q.int_fn, q.srst,
                      q.vis_valid};
  assign bank = {q.yn, q.yp, q.xn, q.xp, q.vis_y, q.vis_x, ctrl_byte};
  assign pub_valid = (bank != q.sent);

  assign wake_tgt = 32'(hjcu_pkg::TB_MS[q.tb] * MS_CYC); // R3 R4
  assign frozen = (q.ptr == hjcu_pkg::ADDR_CTRL) ||
                  (q.ptr == hjcu_pkg::ADDR_X) ||
                  (q.ptr == hjcu_pkg::ADDR_Y);
  // Signed box test on the fresh sample
  assign outside = ($signed(meas_x) > $signed(q.xp)) ||
                   ($signed(meas_x) < $signed(q.xn)) ||
                   ($signed(meas_y) > $signed(q.yp)) ||
                   ($signed(meas_y) < $signed(q.yn)); // R8 R14

  always_comb begin
    logic y_ack;
    logic set_irq;
    logic wake_hit;
    y_ack = 1'b0;
    set_irq = 1'b0;
    wake_hit = 1'b0;
    d = q;
    d.start = 1'b0;

    // Keeps valid flag, X and Y coherent while the host reads them
    if (!frozen) begin
      d.vis_x = q.live_x;
      d.vis_y = q.live_y;
      d.vis_valid = q.live_valid;
    end // R13

    if (cmd_valid) begin
      unique case (cmd_kind)
        hjcu_pkg::HJCU_CMD_PTR: d.ptr = cmd_addr;
        hjcu_pkg::HJCU_CMD_WR: begin
          unique case (cmd_addr)
            hjcu_pkg::ADDR_CTRL: begin
              d.idle = cmd_data[hjcu_pkg::CTRL_IDLE_BIT];
              d.tb = cmd_data[hjcu_pkg::CTRL_TB_MSB:hjcu_pkg::CTRL_TB_LSB];
              d.int_dis = cmd_data[hjcu_pkg::CTRL_INTDIS_BIT];
              d.int_fn = cmd_data[hjcu_pkg::CTRL_INTFN_BIT];
            end // R16
            hjcu_pkg::ADDR_XP: d.xp = cmd_data; // R15
            hjcu_pkg::ADDR_XN: d.xn = cmd_data; // R15
            hjcu_pkg::ADDR_YP: d.yp = cmd_data; // R15
            hjcu_pkg::ADDR_YN: d.yn = cmd_data; // R15
            default: d.ptr = q.ptr;
          endcase
        end
        hjcu_pkg::HJCU_CMD_YACK: y_ack = 1'b1;
        default: d.ptr = q.ptr;
      endcase
    end

    // Low-power wake-up timer
    if (!q.idle) begin
      if (q.wake_cnt >= wake_tgt - 32'h0000_0001) begin
        d.wake_cnt = '0;
        wake_hit = 1'b1;
      end else begin
        d.wake_cnt = q.wake_cnt + 32'h0000_0001;
      end
    end else begin
      d.wake_cnt = '0;
    end // R1

    if (y_ack && q.idle) begin
      d.kick = 1'b1; // R2
      if (!q.int_fn) begin
        d.dly_run = 1'b1;
        d.dly_cnt = '0;
      end
    end

    if (q.dly_run) begin
      if (q.dly_cnt == 32'(IRQ_DLY_CYC - 1)) begin
        d.dly_run = 1'b0;
        set_irq = !q.int_fn; // R6
      end else begin
        d.dly_cnt = q.dly_cnt + 32'h0000_0001;
      end
    end

    unique case (q.meas)
      hjcu_pkg::HJCU_MEAS_IDLE: begin
        if (!q.srst && (q.kick || wake_hit)) begin
          d.meas = hjcu_pkg::HJCU_MEAS_CONV;
          d.start = 1'b1;
          d.kick = 1'b0;
          d.live_valid = 1'b0; // R12
        end
      end
      hjcu_pkg::HJCU_MEAS_CONV: begin
        if (meas_done) begin
          d.meas = hjcu_pkg::HJCU_MEAS_IDLE;
          d.live_x = meas_x; // R14
          d.live_y = meas_y; // R14
          d.live_valid = 1'b1; // R12
          if (q.int_fn) begin
            set_irq = outside; // R8 R9
          end else if (!q.idle) begin
            set_irq = 1'b1; // R6
          end
        end
      end
    endcase

    // A new event in the release cycle keeps the line asserted
    if (y_ack) begin
      d.irq = 1'b0; // R7
    end
    if (set_irq) begin
      d.irq = 1'b1;
    end

    if (q.srst) begin
      if (q.srst_cnt == 4'h0) begin
        d.srst = 1'b0; // R11
      end else begin
        d.srst_cnt = q.srst_cnt - 4'h1;
      end
    end

    if (pub_valid && pub_ready) begin
      d.sent = bank;
    end

    // Pointer lives in the serial engine, so it survives soft reset
    if (cmd_valid && cmd_kind == hjcu_pkg::HJCU_CMD_WR &&
        cmd_addr == hjcu_pkg::ADDR_CTRL &&
        cmd_data[hjcu_pkg::CTRL_SRST_BIT]) begin
      d = CORE_RST;
      d.srst = 1'b1;
      d.srst_cnt = hjcu_pkg::SRST_CYC;
      d.ptr = q.ptr;
      d.sent = q.sent;
    end // R11
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  assign meas_start = q.start;
  // Open drain: only ever pulls low
  assign irq_line_low_active = 1'b0;
  assign irq_line_low_active_oe = q.irq && !q.int_dis; // R5

endmodule

// ### hjcu_pkg.sv
package hjcu_pkg;

  // Device clock rate and interrupt delay in idle data-ready mode
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned IRQ_DLY_US = 450;
  localparam int unsigned MS_PER_S = 1000;

  // Length of the internal soft reset sequence, in device clocks
  localparam logic [3:0] SRST_CYC = 4'h8;

  // Register addresses as seen by the serial engine pointer
  localparam logic [7:0] ADDR_CTRL = 8'h0F;
  localparam logic [7:0] ADDR_X = 8'h10;
  localparam logic [7:0] ADDR_Y = 8'h11;
  localparam logic [7:0] ADDR_XP = 8'h12;
  localparam logic [7:0] ADDR_XN = 8'h13;
  localparam logic [7:0] ADDR_YP = 8'h14;
  localparam logic [7:0] ADDR_YN = 8'h15;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'hF0;
  localparam logic [7:0] COORD_RST = 8'h00;
  localparam logic [7:0] THR_POS_RST = 8'h05;
  localparam logic [7:0] THR_NEG_RST = 8'hFB;

  // Field positions of control_status_one
  localparam int unsigned CTRL_IDLE_BIT = 7;
  localparam int unsigned CTRL_TB_MSB = 6;
  localparam int unsigned CTRL_TB_LSB = 4;
  localparam int unsigned CTRL_INTDIS_BIT = 3;
  localparam int unsigned CTRL_INTFN_BIT = 2;
  localparam int unsigned CTRL_SRST_BIT = 1;
  localparam int unsigned CTRL_VALID_BIT = 0;

  // Wake-up time base in ms, indexed by the three-bit code
  localparam int unsigned TB_MS [8] = '{20, 40, 80, 100, 140, 200, 260, 320};
  localparam int unsigned TB_MS_MAX = 320;

  // Command word from the serial engine: {kind, addr, data}
  localparam int unsigned CMD_W = 18;
  // Read-back bank: {yn, yp, xn, xp, y, x, ctrl}
  localparam int unsigned BANK_W = 56;

  typedef enum logic [1:0] {
    HJCU_CMD_PTR = 2'b00,
    HJCU_CMD_WR = 2'b01,
    HJCU_CMD_YACK = 2'b10
  } hjcu_cmd_t;

  typedef enum logic {
    HJCU_MEAS_IDLE = 1'b0,
    HJCU_MEAS_CONV = 1'b1
  } hjcu_meas_t;

endpackage

// ### hjcu_hs_word.sv
`timescale 1ns/1ps
module hjcu_hs_word #(
  parameter int unsigned W = 8
) (
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [W-1:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic dst_valid,
  output logic [W-1:0] dst_data
);

  typedef struct packed {
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic [W-1:0] data;
  } hjcu_src_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic ack;
    logic valid;
    logic [W-1:0] data;
  } hjcu_dst_t;

  hjcu_src_t src_q, src_d;
  hjcu_dst_t dst_q, dst_d;

  generate
    if (W < 1) begin : g_chk
      $error("hjcu_hs_word: W must be at least 1");
    end
  endgenerate

  // Source holds its word until the toggle comes back, so the
  // destination may sample it without a synchroniser on the data.
  assign src_ready = (src_q.req == src_q.ack_s2);

  always_comb begin
    src_d = src_q;
    src_d.ack_s1 = dst_q.ack;
    src_d.ack_s2 = src_q.ack_s1;
    if (src_valid && src_ready) begin
      src_d.req = ~src_q.req;
      src_d.data = src_data;
    end
  end

  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      src_q <= '0;
    end else begin
      src_q <= src_d;
    end
  end

  always_comb begin
    dst_d = dst_q;
    dst_d.req_s1 = src_q.req;
    dst_d.req_s2 = dst_q.req_s1;
    dst_d.valid = 1'b0;
    if (dst_q.req_s2 != dst_q.ack) begin
      dst_d.ack = dst_q.req_s2;
      dst_d.data = src_q.data;
      dst_d.valid = 1'b1;
    end
  end

  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      dst_q <= '0;
    end else begin
      dst_q <= dst_d;
    end
  end

  assign dst_valid = dst_q.valid;
  assign dst_data = dst_q.data;

endmodule

// ### hjcu_ctrl_chk.sv
`timescale 1ns/1ps
module hjcu_ctrl_chk (
  input logic ref_clk,
  input logic reset_n,
  input logic lk_clk,
  input logic lk_cmd_valid,
  input logic lk_cmd_ready,
  input logic [1:0] lk_cmd_kind,
  input logic [7:0] lk_cmd_addr,
  input logic [7:0] lk_cmd_data,
  input logic [7:0] lk_rd_addr,
  input logic [7:0] lk_rd_data,
  input logic meas_start,
  input logic irq_line_low_active,
  input logic irq_line_low_active_oe
);
  logic take;
  logic dis_q;
  logic [4:0] age_q;
  assign take = lk_cmd_valid && lk_cmd_ready;
  // Aged copy of the disable bit, so the crossing has settled
  always_ff @(posedge lk_clk or negedge reset_n) begin
    if (!reset_n) begin
      dis_q <= 1'b0;
      age_q <= 5'h00;
    end else if (take && lk_cmd_kind == 2'h1 &&
        lk_cmd_addr == hjcu_pkg::ADDR_CTRL) begin
      dis_q <= lk_cmd_data[3] && !lk_cmd_data[1];
      age_q <= 5'h00;
    end else if (age_q != 5'h1f) begin
      age_q <= age_q + 5'h01;
    end
  end
  chk_pin_drives_low: assert property (
    @(posedge ref_clk) disable iff (!reset_n) irq_line_low_active == 1'b0)
    else $error("Pin value not low");
  chk_disable_gates_pin: assert property (
    @(posedge lk_clk) disable iff (!reset_n)
    dis_q && age_q == 5'h1f |-> !irq_line_low_active_oe)
    else $error("Pin driven while disabled");
  chk_start_spacing: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    meas_start |=> !meas_start [*4]) else $error("Start pulses too close");
  chk_boot_start: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(reset_n) |-> ##[1:8] meas_start) else $error("No boot start");
  chk_quiet_boot: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(reset_n) |-> !irq_line_low_active_oe [*3])
    else $error("Pin driven at boot");
  chk_unmapped_zero: assert property (
    @(posedge lk_clk) disable iff (!reset_n)
    lk_rd_addr < 8'h0f || lk_rd_addr > 8'h15 |=> lk_rd_data == 8'h00)
    else $error("Unmapped read not zero");
  chk_take_drops_ready: assert property (
    @(posedge lk_clk) disable iff (!reset_n) take |=> !lk_cmd_ready)
    else $error("Ready held after take");
  chk_ready_returns: assert property (
    @(posedge lk_clk) disable iff (!reset_n)
    take |-> ##[2:40] lk_cmd_ready) else $error("Ready never returns");
  chk_yack_clears: assert property (
    @(posedge lk_clk) disable iff (!reset_n)
    take && lk_cmd_kind == hjcu_pkg::HJCU_CMD_YACK
    |-> ##[1:20] !irq_line_low_active_oe) else $error("Ack left pin low");
endmodule
bind hjcu_ctrl hjcu_ctrl_chk u_chk (.ref_clk, .reset_n, .lk_clk,
  .lk_cmd_valid, .lk_cmd_ready, .lk_cmd_kind, .lk_cmd_addr, .lk_cmd_data,
  .lk_rd_addr, .lk_rd_data, .meas_start, .irq_line_low_active,
  .irq_line_low_active_oe);

// ### hjcu_host_model.sv
`timescale 1ns/1ps
module hjcu_host_model (
  input wire logic lk_clk,
  output logic lk_cmd_valid,
  input wire logic lk_cmd_ready,
  output logic [1:0] lk_cmd_kind,
  output logic [7:0] lk_cmd_addr,
  output logic [7:0] lk_cmd_data,
  output logic [7:0] lk_rd_addr,
  output logic rd_seen
);
  initial begin
    lk_cmd_valid = 1'b0;
    lk_cmd_kind = 2'h0;
    lk_cmd_addr = 8'h00;
    lk_cmd_data = 8'h00;
    lk_rd_addr = 8'h20;
    rd_seen = 1'b0;
  end
  // Held until taken, then scrambled; returns once ready is back
  task automatic cmd(logic [1:0] k, logic [7:0] a, logic [7:0] d);
    @(posedge lk_clk);
    lk_cmd_valid <= 1'b1;
    lk_cmd_kind <= k;
    lk_cmd_addr <= a;
    lk_cmd_data <= d;
    @(negedge lk_clk);
    while (lk_cmd_ready !== 1'b1) @(negedge lk_clk);
    @(posedge lk_clk);
    lk_cmd_valid <= 1'b0;
    lk_cmd_kind <= ~k;
    lk_cmd_addr <= ~a;
    lk_cmd_data <= ~d;
    @(negedge lk_clk);
    while (lk_cmd_ready !== 1'b1) @(negedge lk_clk);
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge lk_clk);
    lk_rd_addr <= a;
    repeat (3) @(posedge lk_clk);
    rd_seen <= 1'b1;
    @(posedge lk_clk);
    rd_seen <= 1'b0;
  endtask
endmodule

// ### hjcu_ctrl_test.sv
`timescale 1ns/1ps
module hjcu_ctrl_test;
  localparam int MSC = 10;
  logic ref_clk = 1'b0;
  logic lk_clk = 1'b0;
  logic reset_n = 1'b0;
  logic lk_cmd_valid, lk_cmd_ready, rd_seen, meas_start;
  logic [1:0] lk_cmd_kind;
  logic [7:0] lk_cmd_addr, lk_cmd_data, lk_rd_addr, lk_rd_data;
  logic meas_done = 1'b0;
  logic [7:0] meas_x = 8'h00;
  logic [7:0] meas_y = 8'h00;
  logic irq_line_low_active, irq_line_low_active_oe;
  logic [7:0] fx, fy, keep;
  logic [2:0] fe_q = 3'h0;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  always #2.5 ref_clk = ~ref_clk;
  always #3 lk_clk = ~lk_clk;
  hjcu_ctrl #(.MS_CYC(MSC), .IRQ_DLY_CYC(20)) DUT (.ref_clk, .reset_n,
    .lk_clk, .lk_cmd_valid, .lk_cmd_ready, .lk_cmd_kind, .lk_cmd_addr,
    .lk_cmd_data, .lk_rd_addr, .lk_rd_data, .meas_start, .meas_done,
    .meas_x, .meas_y, .irq_line_low_active, .irq_line_low_active_oe);
  hjcu_host_model host (.lk_clk, .lk_cmd_valid, .lk_cmd_ready,
    .lk_cmd_kind, .lk_cmd_addr, .lk_cmd_data, .lk_rd_addr, .rd_seen);
  // Front end answers five cycles after a start, scrambled otherwise
  always @(posedge ref_clk) begin
    fe_q <= meas_start ? 3'h5 : fe_q - {2'h0, fe_q != 3'h0};
    meas_done <= fe_q == 3'h1;
    meas_x <= fe_q == 3'h1 ? fx : ~meas_x;
    meas_y <= fe_q == 3'h1 ? fy : ~meas_y;
  end
  task automatic cmp_byte(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_val(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task give_verdict();
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge lk_clk)
    if (rd_seen === 1'b1) cmp_byte("rd", exp_q.pop_front(), lk_rd_data);
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic rc(int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic wr(logic [1:0] k, logic [7:0] a, logic [7:0] d);
    host.cmd(k, a, d);
    rc(30);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  task automatic yack();
    host.cmd(2'h2, 8'h11, 8'h00);
  endtask
  task automatic oe_is(logic e);
    @(negedge ref_clk);
    cmp_val("oe", {31'h0, e}, {31'h0, irq_line_low_active_oe});
  endtask
  task automatic gap(output int g);
    @(negedge ref_clk);
    while (meas_start !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    g = 1;
    while (meas_start !== 1'b1) begin
      @(negedge ref_clk);
      g++;
    end
  endtask
  initial begin
    n = $urandom(32'hd795);
    n = $urandom;
    fx <= n[7:0];
    fy <= n[15:8];
    rc(3);
    reset_n <= 1'b1;
    rc(20);
    wr(2'h0, 8'h20, 8'h00);
    rd(8'h0f, 8'hf1);
    rd(8'h10, fx);
    rd(8'h11, fy);
    rd(8'h30, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(8'h12 + 8'(i), i[0] ? 8'hfb : 8'h05);
      n = $urandom;
      wr(2'h1, 8'h12 + 8'(i), n[7:0]);
      rd(8'h12 + 8'(i), n[7:0]);
    end
    wr(2'h1, 8'h0f, 8'hf0);
    rd(8'h0f, 8'hf1);
    keep = fx;
    n = $urandom;
    fx <= keep + {1'b0, n[6:0]} + 8'h01;
    fy <= n[15:8];
    wr(2'h0, 8'h10, 8'h00);
    yack();
    rc(40);
    rd(8'h10, keep);
    wr(2'h0, 8'h20, 8'h00);
    rd(8'h10, fx);
    rd(8'h11, fy);
    oe_is(1'b1);
    yack();
    oe_is(1'b0);
    rc(30);
    oe_is(1'b1);
    wr(2'h1, 8'h0f, 8'hf8);
    oe_is(1'b0);
    wr(2'h1, 8'h0f, 8'hf0);
    oe_is(1'b1);
    for (int c = 0; c < 8; c++) begin
      host.cmd(2'h1, 8'h0f, {1'b0, c[2:0], 4'h8});
      gap(n);
      cmp_val("gap", hjcu_pkg::TB_MS[c] * MSC, n);
    end
    // Low-power data-ready: every timed measurement pulls the line
    wr(2'h1, 8'h0f, 8'h00);
    gap(n);
    rc(10);
    yack();
    oe_is(1'b0);
    gap(n);
    cmp_val("gap", hjcu_pkg::TB_MS[0] * MSC, n);
    rc(10);
    oe_is(1'b1);
    wr(2'h1, 8'h0f, 8'h02);
    rd(8'h0f, 8'hf1);
    rd(8'h12, 8'h05);
    rd(8'h13, 8'hfb);
    // Signed edges of the box: inside at -5 and +5
    fx <= 8'hfb;
    fy <= 8'h05;
    wr(2'h1, 8'h0f, 8'h04);
    yack();
    gap(n);
    rc(10);
    oe_is(1'b0);
    fx <= 8'h06;
    gap(n);
    rc(10);
    oe_is(1'b1);
    yack();
    oe_is(1'b0);
    fx <= 8'hfa;
    gap(n);
    rc(10);
    oe_is(1'b1);
    give_verdict();
  end
endmodule
